// [ssr_top.sv]
// Purpose: 8-stage serial shift register with a parallel storage latch
// Assumes: shift_clock edges at least 4 ref_clk periods apart; pins asynchronous
// Notes:   parallel_out trails the store_clock pin by about three ref_clk cycles
//
// How it works
// R1: eight stages advance one place on every shift_clock rise unless cleared.
// R2: serial_in is captured into stage zero on each shift_clock rise.
// R3: cascade_out is the last stage, showing stage six's prior value.
// R4: store_clock rise copies all eight stages into storage when no clear.
// R5: parallel_out comes only from storage, changing on load or clear.
// R6: low shift_clear_n zeroes stages and cascade_out, parallel_out untouched.
// R7: low store_clear_n zeroes storage and parallel_out, stages untouched.
// R8: store rise during shift clear loads zeros into storage.
// R9: simultaneous clock rises load storage with pre-shift contents.
// R10: without edges registers hold; a clear beats a clock edge.
// R11: controller sends eight bits first-bit-first, then one store pulse.
`include "ssr_map.svh"
`default_nettype none

module ssr_top
  import ssr_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              shift_clock,
  input  wire logic              serial_in,
  input  wire logic              shift_clear_n,
  input  wire logic              store_clock,
  input  wire logic              store_clear_n,
  output var  logic              cascade_out,
  output var  ssr_word_t         parallel_out
);

  // ========================================================================
  // link domain: the shift stages on shift_clock
  ssr_word_t shift_stage_values_ff;
  logic      shift_toggle_ff;

  // the clear acts without a clock edge, so it is the async reset here
  always_ff @(posedge shift_clock or negedge shift_clear_n) begin
    if (!shift_clear_n) begin
      shift_stage_values_ff <= `SSR_STAGE_RST;                     // [R6] [R10]
      shift_toggle_ff       <= 1'b0;
    end else begin
      shift_stage_values_ff <= {shift_stage_values_ff[`SSR_STAGES-2:0], serial_in}; // [R1] [R2]
      shift_toggle_ff       <= ~shift_toggle_ff;
    end
  end

  assign cascade_out = shift_stage_values_ff[`SSR_STAGES-1];        // [R3]

  // ========================================================================
  // crossing into ref_clk
  ssr_cross_t cross_raw;
  ssr_cross_t cross_s;

  assign cross_raw = '{store_clock:   store_clock,
                       store_clear_n: store_clear_n,
                       shift_clear_n: shift_clear_n,
                       shift_toggle:  shift_toggle_ff};

  ssr_sync #(
    .WIDTH   (`SSR_SYNC_BITS),
    .RST_VAL (`SSR_SYNC_RST)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (cross_raw),
    .sync_out (cross_s)
  );

  // ========================================================================
  // edge and change detection
  logic      store_prev_ff;
  logic      toggle_prev_ff;
  ssr_word_t mirror_ff;
  ssr_word_t storage_ff;
  ssr_word_t nxt_mirror;
  ssr_word_t nxt_storage;
  wire       store_rise = cross_s.store_clock & ~store_prev_ff;
  wire       shift_seen = cross_s.shift_toggle ^ toggle_prev_ff;
  wire       load_ok    = store_rise & cross_s.store_clear_n;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      store_prev_ff  <= 1'b0;
      toggle_prev_ff <= 1'b0;
    end else begin
      store_prev_ff  <= cross_s.store_clock;
      toggle_prev_ff <= cross_s.shift_toggle;
    end
  end

  // ========================================================================
  // mirror of the stages; the word has been stable for two ref_clk cycles
  // when the toggle arrives, so the multi-bit read is safe
  assign nxt_mirror = !cross_s.shift_clear_n ? `SSR_STAGE_RST :
                      shift_seen             ? shift_stage_values_ff :
                                               mirror_ff;

  // storage reads the old mirror, so a same-cycle shift lands next time
  assign nxt_storage = !cross_s.store_clear_n  ? `SSR_STAGE_RST :      // [R7] [R10]
                       !load_ok                ? storage_ff :          // [R10]
                       !cross_s.shift_clear_n  ? `SSR_STAGE_RST :      // [R8]
                                                 mirror_ff;            // [R4] [R9]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mirror_ff  <= `SSR_STAGE_RST;
      storage_ff <= `SSR_STAGE_RST;
    end else begin
      mirror_ff  <= nxt_mirror;
      storage_ff <= nxt_storage;
    end
  end

  assign parallel_out = storage_ff;                                 // [R5]

  // ========================================================================
  // checks, link domain
  chk_shift_advance: assert property (                              // [R1]
    @(posedge shift_clock) disable iff (!shift_clear_n)
    1 |=> shift_stage_values_ff[`SSR_STAGES-1:1] == $past(shift_stage_values_ff[`SSR_STAGES-2:0]))
    else $error("stages did not advance by one");

  chk_stage_zero: assert property (                                 // [R2]
    @(posedge shift_clock) disable iff (!shift_clear_n)
    1 |=> shift_stage_values_ff[0] == $past(serial_in))
    else $error("stage zero missed serial_in");

  chk_cascade_six: assert property (                                // [R3]
    @(posedge shift_clock) disable iff (!shift_clear_n)
    1 |=> cascade_out == $past(shift_stage_values_ff[6]))
    else $error("cascade_out not prior stage six");

  chk_toggle_flip: assert property (                                // [R1]
    @(posedge shift_clock) disable iff (!shift_clear_n)
    1 |=> shift_toggle_ff != $past(shift_toggle_ff))
    else $error("shift toggle did not flip");

  // no disable here: the clear itself is the condition under test
  chk_link_clear: assert property (                                 // [R6]
    @(posedge shift_clock)
    !shift_clear_n |-> (shift_stage_values_ff == `SSR_STAGE_RST) && !cascade_out && !shift_toggle_ff)
    else $error("link clear left stages set");

  // ========================================================================
  // checks, system domain
  sequence s_store_load;
    store_rise && cross_s.store_clear_n && cross_s.shift_clear_n;
  endsequence

  sequence s_both_rise;
    s_store_load ##0 shift_seen;
  endsequence

  sequence s_shift_arrive;
    shift_seen && cross_s.shift_clear_n;
  endsequence

  chk_store_copy: assert property (                                 // [R4]
    @(posedge ref_clk) disable iff (rst)
    s_store_load |=> parallel_out == $past(mirror_ff))
    else $error("storage did not copy the stages");

  chk_out_hold: assert property (                                   // [R5]
    @(posedge ref_clk) disable iff (rst)
    (!store_rise && cross_s.store_clear_n) |=> $stable(parallel_out))
    else $error("parallel_out moved without load or clear");

  chk_shift_clear: assert property (                                // [R6]
    @(posedge ref_clk) disable iff (rst)
    (!cross_s.shift_clear_n && !$past(cross_s.shift_clear_n)) |->
      (shift_stage_values_ff == `SSR_STAGE_RST) && !cascade_out)
    else $error("shift clear left stages set");

  chk_store_clear: assert property (                                // [R7]
    @(posedge ref_clk) disable iff (rst)
    !cross_s.store_clear_n |=> parallel_out == `SSR_STAGE_RST)
    else $error("store clear left outputs set");

  chk_empty_load: assert property (                                 // [R8]
    @(posedge ref_clk) disable iff (rst)
    (store_rise && !cross_s.shift_clear_n && cross_s.store_clear_n) |=>
      parallel_out == `SSR_STAGE_RST)
    else $error("load during shift clear not zero");

  chk_both_lag: assert property (                                   // [R9]
    @(posedge ref_clk) disable iff (rst)
    s_both_rise |=> (parallel_out == $past(mirror_ff)) && (mirror_ff == $past(shift_stage_values_ff)))
    else $error("storage did not lag shift by one");

  chk_idle_hold: assert property (                                  // [R10]
    @(posedge ref_clk) disable iff (rst)
    (!shift_seen && cross_s.shift_clear_n && !store_rise && cross_s.store_clear_n) |=>
      $stable(mirror_ff) && $stable(parallel_out))
    else $error("registers changed without edge");

  chk_mirror_follow: assert property (                              // [R1]
    @(posedge ref_clk) disable iff (rst)
    s_shift_arrive |=> mirror_ff == $past(shift_stage_values_ff))
    else $error("mirror missed a shift");

  chk_mirror_clear: assert property (                               // [R6]
    @(posedge ref_clk) disable iff (rst)
    !cross_s.shift_clear_n |=> mirror_ff == `SSR_STAGE_RST)
    else $error("mirror kept data under shift clear");

  chk_clear_wins: assert property (                                 // [R10]
    @(posedge ref_clk) disable iff (rst)
    (store_rise && !cross_s.store_clear_n) |=> parallel_out == `SSR_STAGE_RST)
    else $error("load beat the storage clear");

  // any move of parallel_out must trace back to a load or a clear
  chk_out_cause: assert property (                                  // [R5]
    @(posedge ref_clk) disable iff (rst)
    !$stable(parallel_out) |->
      $past(load_ok) || !$past(cross_s.store_clear_n))
    else $error("parallel_out moved with no cause");

endmodule

`default_nettype wire

// [ssr_map.svh]
// Purpose: constants for the serial shift and storage latch block
// Assumes: included by bare name before any module that uses it
// Notes:   widths and reset values only, no logic
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// ==========================================================================
// sizes
`define SSR_STAGES      8
`define SSR_SYNC_BITS   4

// ==========================================================================
// reset values
`define SSR_STAGE_RST   8'h00
`define SSR_SYNC_RST    4'h6

`endif

// [ssr_pkg.sv]
// Purpose: shared types for the serial shift and storage latch block
// Assumes: ssr_map.svh holds the numeric constants
// Notes:   the sync bundle order matches the reset value in the map header
`include "ssr_map.svh"
`default_nettype none

package ssr_pkg;

  // ========================================================================
  // pin levels and the shift toggle that cross into the system clock domain
  typedef struct packed {
    logic store_clock;
    logic store_clear_n;
    logic shift_clear_n;
    logic shift_toggle;
  } ssr_cross_t;

  typedef logic [`SSR_STAGES-1:0] ssr_word_t;

endpackage

`default_nettype wire

// [ssr_sync.sv]
// Purpose: two-flop level synchroniser, one lane per bit
// Assumes: inputs are levels held for several destination clocks
// Notes:   first stage feeds only the second stage
`include "ssr_map.svh"
`default_nettype none

module ssr_sync
  import ssr_pkg::*;
#(
  parameter int unsigned                WIDTH   = `SSR_SYNC_BITS,
  parameter logic [`SSR_SYNC_BITS-1:0]  RST_VAL = `SSR_SYNC_RST
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // ========================================================================
  // per-bit two-flop chain
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_lane
    logic meta_ff;
    logic hold_ff;
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        meta_ff <= RST_VAL[g];
        hold_ff <= RST_VAL[g];
      end else begin
        meta_ff <= async_in[g];
        hold_ff <= meta_ff;
      end
    end
    assign sync_out[g] = hold_ff;
  end

endmodule

`default_nettype wire

// [ssr_host.sv]
// Purpose: host model driving the serial link and the storage clock
// Assumes: link clock runs only while a bit is sent, 160 ns period
// Notes:   bits leave most significant first
`default_nettype none

module ssr_host
  import ssr_pkg::*;
(
  output var logic shift_clock,
  output var logic serial_in,
  output var logic store_clock
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // link driving
  initial begin
    shift_clock = 1'b0;
    serial_in   = 1'b0;
    store_clock = 1'b0;
  end

  // odd offset puts the serial_in change off the system clock grid; link edges still come 40 ns after the task starts
  task automatic shift_bit(input logic b, input logic with_store);
    #3.3;
    serial_in   = b;
    #36.7;
    shift_clock = 1'b1;
    store_clock = with_store;
    #80;
    shift_clock = 1'b0;
    store_clock = 1'b0;
    #40;
    serial_in   = ~b; // stale data must not look valid
  endtask

  task automatic send_byte(input ssr_word_t w);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(w[i], 1'b0);
    end
  endtask

  task automatic store_pulse();
    #40;
    store_clock = 1'b1;
    #40;
    store_clock = 1'b0;
    #40;
  endtask
endmodule

`default_nettype wire

// [ssr_top_tb_top.sv]
// Purpose: self-checking bench for the shift and storage latch block
// Assumes: host model owns the link and storage clock pins
// Notes:   clears are driven here, 1 ns after the system clock edge
`default_nettype none

module ssr_top_tb_top
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic      ref_clk;
  logic      rst;
  logic      shift_clock;
  logic      serial_in;
  logic      shift_clear_n;
  logic      store_clock;
  logic      store_clear_n;
  logic      cascade_out;
  ssr_word_t parallel_out;
  ssr_word_t exp_q;
  int        n_errors;
  int        num_checks;
  int        cycles;

  ssr_top u_ssr_top (.ref_clk(ref_clk), .rst(rst), .shift_clock(shift_clock), .serial_in(serial_in),
    .shift_clear_n(shift_clear_n), .store_clock(store_clock), .store_clear_n(store_clear_n),
    .cascade_out(cascade_out), .parallel_out(parallel_out));

  ssr_host u_ssr_host (.shift_clock(shift_clock), .serial_in(serial_in), .store_clock(store_clock));

  // ==========================================================================
  // helpers
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic set_clears(input logic sh, input logic st);
    @(posedge ref_clk);
    #1;
    shift_clear_n = sh;
    store_clear_n = st;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic t_load(input ssr_word_t w);
    u_ssr_host.send_byte(w);
    check(parallel_out, exp_q);
    check({7'h0, cascade_out}, {7'h0, w[7]});
    u_ssr_host.shift_bit(1'b0, 1'b0);
    check({7'h0, cascade_out}, {7'h0, w[6]});
    u_ssr_host.store_pulse();
    exp_q = {w[6:0], 1'b0};
    check(parallel_out, exp_q);
  endtask

  task automatic t_both();
    u_ssr_host.send_byte(8'hc3);
    u_ssr_host.shift_bit(1'b1, 1'b1);
    check(parallel_out, 8'hc3);
    u_ssr_host.store_pulse();
    exp_q = 8'h87;
    check(parallel_out, exp_q);
  endtask

  task automatic t_shift_clear();
    set_clears(1'b0, 1'b1);
    check({7'h0, cascade_out}, 8'h00);
    check(parallel_out, exp_q);
    u_ssr_host.shift_bit(1'b1, 1'b0);
    u_ssr_host.store_pulse();
    check(parallel_out, 8'h00);
    set_clears(1'b1, 1'b1);
    u_ssr_host.store_pulse();
    check(parallel_out, 8'h00);
  endtask

  task automatic t_store_clear();
    u_ssr_host.send_byte(8'h96);
    u_ssr_host.store_pulse();
    check(parallel_out, 8'h96);
    set_clears(1'b1, 1'b0);
    check(parallel_out, 8'h00);
    check({7'h0, cascade_out}, 8'h01);
    u_ssr_host.store_pulse();
    check(parallel_out, 8'h00);
    set_clears(1'b1, 1'b1);
    check(parallel_out, 8'h00);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    rst           = 1'b1;
    shift_clear_n = 1'b0;
    store_clear_n = 1'b1;
    exp_q         = 8'h00;
    n_errors      = 0;
    num_checks    = 0;
    cycles        = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst           = 1'b0;
    shift_clear_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    // keeps host link edges and checks off the system clock edge
    #1;
    check(parallel_out, 8'h00);
    check({7'h0, cascade_out}, 8'h00);
    t_load(8'ha5);
    t_load(8'h5a);
    t_both();
    t_shift_clear();
    t_store_clear();
    report_and_stop();
  end
endmodule

`default_nettype wire
